// >>> verilog/urx_pkg.sv
// Purpose: shared constants and carriers for the ulpi register access and status block
// Assumes: single 60 MHz ulpi clock domain
// Notes: command encodings and status byte layout
package urx_pkg;
  localparam logic [1:0] CMD_IDLE = 2'h0;
  localparam logic [1:0] CMD_TX = 2'h1;
  localparam logic [1:0] CMD_WRITE = 2'h2;
  localparam logic [1:0] CMD_READ = 2'h3;
  localparam logic [5:0] EXT_ADDR = 6'h2F;
  localparam logic [7:0] IDLE_BYTE = 8'h00;
  localparam int CMD_HI = 7;
  localparam int CMD_LO = 6;
  localparam int ADDR_HI = 5;
  localparam logic [1:0] VB_BELOW_END = 2'h0;
  localparam logic [1:0] VB_END_TO_VALID = 2'h1;
  localparam logic [1:0] VB_VALID_TO_BUS = 2'h2;
  localparam logic [1:0] VB_BUS_VALID = 2'h3;
  localparam logic [1:0] EV_NONE = 2'h0;

  // live line and comparator status
  typedef struct packed {
    logic alt_int;
    logic id_level;
    logic [1:0] rx_event;
    logic session_end_flag;
    logic session_valid_flag;
    logic bus_power_valid_flag;
    logic [1:0] line_state;
  } urx_status_s;

  // register file access port
  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] data;
  } urx_reg_req_s;
endpackage : urx_pkg

// >>> verilog/urx_ulpi_core.sv
// Purpose: ulpi transceiver-side register access and receive-command status sender
// Assumes: sys_clk is the ulpi clock; status inputs may be asynchronous
// Notes: packet datapaths and the register store itself live outside
// Operation
// - write command has top bits 10b, low six bits register address.
// - nxt rises two cycles after command; data accepted, nxt drops next cycle.
// - link sends idle and pulses stop; data committed after stop deasserts.
// - direction stays low through a whole register write; the core sets dir in ST_CMD if rx_active is high as the command is taken.
// - address 2Fh selects extended access; extra address byte precedes data.
// - immediate read: nxt, then dir up nxt down, turnaround, data, release.
// - extended read takes address byte then behaves like immediate read.
// - status byte sent only in synchronous mode while owning the bus.
// - status sent on line, comparator, receive, start-up and mode-exit events.
// - during receive, status byte each cycle with nxt low and dir high.
// - status events during transmit wait until stop deasserts; current value sent.
// - bits 1:0 line state; bits 3:2 encode vbus level.
// - bit 6 id pin level; bit 7 unmasked alternate interrupt.
// - each direction change except the receive-end drop gets one ignored turnaround cycle; the core decodes data_in in the first cycle after that drop.
module urx_ulpi_core
  import urx_pkg::*;
#(
  parameter int SYNC_STAGES = 3
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // ulpi bus
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic dir,
  output logic nxt,
  input wire logic stp,
  // mode and packet-path context
  input wire logic sync_mode,
  input wire logic rx_active,
  input wire logic tx_active,
  input wire logic startup,
  input wire logic mode_exit,
  // asynchronous status sources
  input wire urx_status_s status_raw,
  // register store port
  output urx_reg_req_s reg_req,
  input wire logic [7:0] reg_rdata
);
  typedef enum {
    ST_IDLE, ST_CMD, ST_NXT, ST_EXT, ST_DATA, ST_STOP, ST_COMMIT,
    ST_RD_TURN, ST_RD_DATA, ST_TA_BACK, ST_ST_TURN, ST_ST_SEND
  } urx_state_e;

  localparam int SW = $bits(urx_status_s);

  urx_state_e state;
  urx_state_e next_state;
  logic [SW-1:0] sync1, sync2, sync3;
  urx_status_s status;
  urx_status_s status_prev;
  logic [7:0] cmd;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic ext;
  logic pending;
  logic change;
  logic was_tx;
  logic stp_d;
  logic [7:0] status_byte;

  function automatic logic [1:0] vbus_code(input urx_status_s s);
    if (s.bus_power_valid_flag) vbus_code = VB_BUS_VALID;
    else if (s.session_valid_flag) vbus_code = VB_VALID_TO_BUS;
    else if (s.session_end_flag) vbus_code = VB_BELOW_END;
    else vbus_code = VB_END_TO_VALID;
  endfunction : vbus_code

  // three-stage synchroniser; change counts when stages two and three agree
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      status <= '0;
    end else begin
      sync1 <= status_raw;
      sync2 <= sync1;
      sync3 <= sync2;
      if (sync2 == sync3) status <= urx_status_s'(sync3);
    end
  end

  // current status at the moment of sending
  always_comb begin
    status_byte = {status.alt_int, status.id_level, status.rx_event,
                   vbus_code(status), status.line_state};
  end

  // status event detection: set wins over the clear of sending
  assign change = (status != status_prev) || startup || mode_exit;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_prev <= '0;
      pending <= 1'b0;
      was_tx <= 1'b0;
      stp_d <= 1'b0;
    end else begin
      status_prev <= status;
      was_tx <= tx_active;
      stp_d <= stp;
      if (change) pending <= 1'b1;
      else if (state == ST_ST_SEND) pending <= 1'b0;
    end
  end

  // command capture
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd <= IDLE_BYTE;
      addr <= IDLE_BYTE;
      wdata <= IDLE_BYTE;
      ext <= 1'b0;
    end else begin
      if (state == ST_IDLE && !dir && !tx_active) begin
        cmd <= data_in;
        addr <= {2'h0, data_in[ADDR_HI:0]};
        ext <= (data_in[ADDR_HI:0] == EXT_ADDR);
      end
      if (state == ST_EXT) addr <= data_in;
      if (state == ST_DATA) wdata <= data_in;
    end
  end

  logic tx_block;
  assign tx_block = tx_active || was_tx || stp_d;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (sync_mode && !tx_active &&
            (data_in[CMD_HI:CMD_LO] == CMD_WRITE || data_in[CMD_HI:CMD_LO] == CMD_READ))
          next_state = ST_CMD;
        else if (sync_mode && pending && !tx_block && !stp && !rx_active)
          next_state = ST_ST_TURN;
      end
      ST_CMD: next_state = ST_NXT;
      ST_NXT: begin
        if (ext) next_state = ST_EXT;
        else if (cmd[CMD_HI:CMD_LO] == CMD_READ) next_state = ST_RD_TURN;
        else next_state = ST_DATA;
      end
      ST_EXT: begin
        if (cmd[CMD_HI:CMD_LO] == CMD_READ) next_state = ST_RD_TURN;
        else next_state = ST_DATA;
      end
      ST_DATA: next_state = ST_STOP;
      ST_STOP: if (stp) next_state = ST_COMMIT;
      ST_COMMIT: next_state = ST_IDLE;
      ST_RD_TURN: next_state = ST_RD_DATA;
      ST_RD_DATA: next_state = ST_TA_BACK;
      ST_ST_TURN: next_state = ST_ST_SEND;
      ST_ST_SEND: next_state = ST_TA_BACK;
      ST_TA_BACK: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) state <= ST_IDLE;
    else state <= next_state;
  end

  // bus outputs: dir low for all write states except ST_CMD entered while rx_active is high
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dir <= 1'b0;
      nxt <= 1'b0;
      data_out <= IDLE_BYTE;
      data_oe <= 1'b0;
    end else begin
      dir <= (next_state == ST_RD_TURN) || (next_state == ST_RD_DATA) ||
             (next_state == ST_ST_TURN) || (next_state == ST_ST_SEND) ||
             (sync_mode && rx_active && state == ST_IDLE);
      nxt <= (next_state == ST_NXT) || (next_state == ST_EXT) ||
             (next_state == ST_DATA);
      data_oe <= (next_state == ST_RD_DATA) || (next_state == ST_ST_SEND) ||
                 (sync_mode && rx_active && dir && state == ST_IDLE);
      if (next_state == ST_RD_DATA) data_out <= reg_rdata;
      else if (next_state == ST_ST_SEND || (rx_active && dir))
        data_out <= status_byte;
      else data_out <= IDLE_BYTE;
    end
  end

  // register store strobes; write commits after stop drops
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) reg_req <= '0;
    else begin
      reg_req.write <= (state == ST_COMMIT) && !stp;
      reg_req.read <= (next_state == ST_RD_TURN);
      reg_req.addr <= (next_state == ST_RD_TURN) ? (state == ST_EXT ? data_in : addr) : addr;
      reg_req.data <= wdata;
    end
  end
endmodule : urx_ulpi_core

// >>> tb/urx_ulpi_core_assertions.sv
// Purpose: port assertions for the ulpi core
// Assumes: one clock, async active-low reset
// Notes: bound to every core instance
module urx_ulpi_core_assertions
  import urx_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // bus and context
  input wire logic [7:0] data_in,
  input wire logic data_oe,
  input wire logic dir,
  input wire logic nxt,
  input wire logic stp,
  input wire logic sync_mode,
  input wire logic rx_active,
  input wire urx_reg_req_s reg_req
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  chk_cmd_to_nxt: assert property ($rose(nxt) |-> $past(data_in[7], 2))
    else $error("nxt rose without command");
  chk_nxt_dir_low: assert property (nxt && !rx_active |-> !dir)
    else $error("nxt with dir high");
  chk_nxt_short: assert property (nxt && !dir |-> ##[1:3] !nxt)
    else $error("nxt held too long");
  chk_turn_around: assert property ($rose(dir) |-> !data_oe && !nxt)
    else $error("no turnaround cycle");
  chk_oe_owner: assert property (data_oe |-> dir && sync_mode)
    else $error("bus driven without ownership");
  chk_byte_release: assert property ($rose(data_oe) && !rx_active |=> !data_oe && !dir)
    else $error("byte not released");
  chk_commit_stp: assert property (reg_req.write |-> !stp && ($past(stp) || $past(stp, 2)))
    else $error("write commit not after stop");
  chk_write_once: assert property (reg_req.write |=> !reg_req.write)
    else $error("write strobe repeated");
endmodule : urx_ulpi_core_assertions

bind urx_ulpi_core urx_ulpi_core_assertions u_chk (.sys_clk(sys_clk), .rst_b(rst_b),
  .data_in(data_in), .data_oe(data_oe), .dir(dir), .nxt(nxt), .stp(stp),
  .sync_mode(sync_mode), .rx_active(rx_active), .reg_req(reg_req));

// >>> tb/urx_link_model.sv
// Purpose: link model issuing register commands
// Assumes: changes made at the falling edge
// Notes: released bus shows the inverse of the last byte
module urx_link_model
  import urx_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // ulpi bus
  input wire logic dir,
  input wire logic nxt,
  input wire logic [7:0] rd_bus,
  output logic [7:0] bus,
  output logic stp = 1'b0
);
  logic [7:0] drv = IDLE_BYTE;
  assign bus = dir ? ~drv : drv;
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] xa, input logic [7:0] wd,
                      output logic [7:0] rd);
    int n;
    n = 0;
    rd = IDLE_BYTE;
    while (dir && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    drv = cmd;
    do @(negedge sys_clk); while (!nxt && ++n < 48);
    // hold the command through the edge that samples nxt high
    @(negedge sys_clk);
    if (cmd[5:0] == EXT_ADDR) begin
      drv = xa;
      @(negedge sys_clk);
    end
    if (cmd[7:6] == CMD_WRITE) begin
      drv = wd;
      @(negedge sys_clk);
      stp = 1'b1;
      drv = IDLE_BYTE;
      @(negedge sys_clk);
      stp = 1'b0;
    end else begin
      // read byte stands between turnaround and release
      @(negedge sys_clk);
      rd = rd_bus;
      drv = IDLE_BYTE;
      @(negedge sys_clk);
    end
  endtask : xfer
endmodule : urx_link_model

// >>> tb/urx_ulpi_core_bench.sv
// Purpose: self-checking bench for the ulpi core
// Assumes: 5 ns clock, inputs driven at the falling edge
// Notes: store returns address xor 5Ah
module urx_ulpi_core_bench
  import urx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, rst_b = 1'b0, startup = 1'b0, dir, nxt, stp, data_oe;
  logic [7:0] data_in, data_out, exp_a, rd_val;
  urx_status_s status_raw = '0;
  urx_reg_req_s reg_req;
  int err_total = 0, num_checks = 0, cyc = 0;
  logic [7:0] cmds [4] = '{8'h85, 8'hAF, 8'hC7, 8'hEF};
  logic [7:0] xas [4] = '{8'h00, 8'h81, 8'h00, 8'h90};
  initial forever #2.5 sys_clk = ~sys_clk;
  urx_link_model u_link (.sys_clk(sys_clk), .dir(dir), .nxt(nxt), .rd_bus(data_out),
    .bus(data_in), .stp(stp));
  urx_ulpi_core u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .dir(dir), .nxt(nxt), .stp(stp),
    .sync_mode(1'b1), .rx_active(1'b0), .tx_active(1'b0), .startup(startup),
    .mode_exit(1'b0), .status_raw(status_raw), .reg_req(reg_req),
    .reg_rdata(reg_req.addr ^ 8'h5A));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wt(input bit wr);
    for (int n = 0; n < 40 && (wr ? reg_req.write : data_oe) !== 1'b1; n++) @(negedge sys_clk);
  endtask : wt
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  always @(posedge sys_clk) if (++cyc > 3000) begin
    err_total++;
    test_done();
  end
  initial begin
    repeat (8) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge sys_clk);
    for (int i = 0; i < 4; i++) begin
      exp_a = (cmds[i][5:0] == EXT_ADDR) ? xas[i] : {2'h0, cmds[i][5:0]};
      u_link.xfer(cmds[i], xas[i], 8'h3C ^ exp_a, rd_val);
      if (cmds[i][6]) chk(rd_val, exp_a ^ 8'h5A);
      else begin
        wt(1'b1);
        chk({7'h00, reg_req.write}, 8'h01);
        chk({reg_req.addr ^ exp_a} | {reg_req.data ^ 8'h3C ^ exp_a}, 8'h00);
      end
      repeat (3) @(negedge sys_clk);
    end
    status_raw.alt_int = 1'b1;
    status_raw.id_level = 1'b1;
    status_raw.line_state = 2'h2;
    wt(1'b0);
    chk(data_out, 8'hC6);
    repeat (8) @(negedge sys_clk);
    status_raw.session_end_flag = 1'b1;
    wt(1'b0);
    chk(data_out, 8'hC2);
    repeat (8) @(negedge sys_clk);
    startup = 1'b1;
    @(negedge sys_clk);
    startup = 1'b0;
    wt(1'b0);
    chk(data_out, 8'hC2);
    test_done();
  end
endmodule : urx_ulpi_core_bench
